// ===== inc/scu_pkg.sv
// Package for the shift and compare datapath.
// Assumes a 30-bit ones-complement word and a 3-bit j field.
package scu_pkg;

	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int WORD_W = 30;
	localparam int SIGN_POS = 29;
	localparam int PAIR_W = 60;
	localparam int CNT_W = 6;
	localparam logic [5:0] MAX_COUNT = 6'h3B;
	localparam logic [5:0] FULL_FILL_COUNT = 6'h1D;

	// ----------------------------------------------------------------
	// Operation select
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCU_SHIFT_RIGHT,
		SCU_ROTATE_LEFT,
		SCU_COMPARE
	} scu_op_t;

	typedef enum logic [1:0] {
		SCU_SEL_AUX,
		SCU_SEL_ACC,
		SCU_SEL_PAIR
	} scu_sel_t;

	// ----------------------------------------------------------------
	// Normal j codes
	// ----------------------------------------------------------------
	localparam logic [2:0] J_NEVER = 3'h0;
	localparam logic [2:0] J_ALWAYS = 3'h1;
	localparam logic [2:0] J_AUX_POS = 3'h2;
	localparam logic [2:0] J_AUX_NEG = 3'h3;
	localparam logic [2:0] J_ACC_ZERO = 3'h4;
	localparam logic [2:0] J_ACC_NZ = 3'h5;
	localparam logic [2:0] J_ACC_POS = 3'h6;
	localparam logic [2:0] J_ACC_NEG = 3'h7;

	// ----------------------------------------------------------------
	// Compare j codes
	// ----------------------------------------------------------------
	localparam logic [2:0] J_LE_AUX = 3'h2;
	localparam logic [2:0] J_GT_AUX = 3'h3;
	localparam logic [2:0] J_IN_RANGE = 3'h4;
	localparam logic [2:0] J_OUT_RANGE = 3'h5;
	localparam logic [2:0] J_LE_ACC = 3'h6;
	localparam logic [2:0] J_GT_ACC = 3'h7;

endpackage

// ===== design/scu_shift_compare.sv
// Shift and compare execution datapath with its own acc and aux words.
// Assumes the sequencer pulses start with op, sel, operand and j valid,
// and waits for done before the next start.
`timescale 1ns/10ps

module scu_shift_compare (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire scu_pkg::scu_op_t op,
	input wire scu_pkg::scu_sel_t sel,
	input wire logic [29:0] operand,
	input wire logic [2:0] jfield,
	input wire logic load_acc,
	input wire logic load_aux,
	input wire logic [29:0] load_data,
	output logic [29:0] acc_ff,
	output logic [29:0] aux_ff,
	output logic done_ff,
	output logic skip_ff
);

	// ----------------------------------------------------------------
	// Ones-complement helpers
	// ----------------------------------------------------------------
	// Rank key: -0 maps below +0, so plain signed order is exact
	function automatic logic signed [31:0] rank(input logic [29:0] w);
		logic signed [31:0] r;
		r = 32'sh0;
		if (w[scu_pkg::SIGN_POS])
			r = -$signed({2'h0, ~w}) - 32'sh1;
		else
			r = $signed({2'h0, w});
		return r;
	endfunction

	function automatic logic is_neg(input logic [29:0] w);
		return w[scu_pkg::SIGN_POS];
	endfunction

	// ----------------------------------------------------------------
	// Shifter
	// ----------------------------------------------------------------
	wire logic [5:0] cnt = operand[5:0];
	wire logic acc_sign = acc_ff[scu_pkg::SIGN_POS];
	wire logic aux_sign = aux_ff[scu_pkg::SIGN_POS];
	wire logic [29:0] one_src = (sel == scu_pkg::SCU_SEL_ACC) ? acc_ff : aux_ff;
	wire logic one_sign = (sel == scu_pkg::SCU_SEL_ACC) ? acc_sign : aux_sign;
	wire logic [59:0] pair_src = {acc_ff, aux_ff};

	// Single-word right shift, sign extended to 60 bits then cut;
	// counts past 29 leave only sign copies
	wire logic [59:0] one_ext = {{30{one_sign}}, one_src};
	wire logic [59:0] one_rsh = 60'($signed(one_ext) >>> cnt);
	// Single-word rotate via doubled word; counts of 30 and up have 30 taken off once
	wire logic [5:0] cnt30 = (cnt >= 6'h1E) ? 6'(cnt - 6'h1E) : cnt;
	wire logic [59:0] one_dbl = {one_src, one_src} << cnt30;
	wire logic [29:0] one_rol = one_dbl[59:30];
	// Pair shifts over a 120-bit view
	wire logic [119:0] pair_ext = {{60{acc_sign}}, pair_src};
	wire logic [119:0] pair_rsh = 120'($signed(pair_ext) >>> cnt);
	wire logic [119:0] pair_dbl = {pair_src, pair_src} << cnt;
	wire logic [59:0] pair_rol = pair_dbl[119:60];

	// Result words; unsupported counts just give whatever falls out
	logic [29:0] res_acc;
	logic [29:0] res_aux;
	always_comb begin
		res_acc = acc_ff;
		res_aux = aux_ff;
		if (op == scu_pkg::SCU_SHIFT_RIGHT) begin
			if (sel == scu_pkg::SCU_SEL_PAIR)
				{res_acc, res_aux} = pair_rsh[59:0];
			else if (sel == scu_pkg::SCU_SEL_ACC)
				res_acc = one_rsh[29:0];
			else
				res_aux = one_rsh[29:0];
		end else if (op == scu_pkg::SCU_ROTATE_LEFT) begin
			if (sel == scu_pkg::SCU_SEL_PAIR)
				{res_acc, res_aux} = pair_rol;
			else if (sel == scu_pkg::SCU_SEL_ACC)
				res_acc = one_rol;
			else
				res_aux = one_rol;
		end
	end

	// ----------------------------------------------------------------
	// Skip decision
	// ----------------------------------------------------------------
	wire logic signed [31:0] y_rank = rank(operand);
	wire logic signed [31:0] acc_rank = rank(acc_ff);
	wire logic signed [31:0] aux_rank = rank(aux_ff);
	wire logic le_aux = y_rank <= aux_rank;
	wire logic le_acc = y_rank <= acc_rank;
	wire logic in_range = le_aux && !le_acc;

	// Compare codes; range codes only count on the pair form
	logic cmp_skip;
	always_comb begin
		cmp_skip = 1'b0;
		unique case (jfield)
			scu_pkg::J_NEVER: cmp_skip = 1'b0;
			scu_pkg::J_ALWAYS: cmp_skip = 1'b1;
			scu_pkg::J_LE_AUX: cmp_skip = le_aux;
			scu_pkg::J_GT_AUX: cmp_skip = !le_aux;
			scu_pkg::J_IN_RANGE:
				cmp_skip = (sel == scu_pkg::SCU_SEL_PAIR) && in_range;
			scu_pkg::J_OUT_RANGE:
				cmp_skip = (sel == scu_pkg::SCU_SEL_PAIR) && !in_range;
			scu_pkg::J_LE_ACC: cmp_skip = le_acc;
			scu_pkg::J_GT_ACC: cmp_skip = !le_acc;
		endcase
	end

	// Normal codes judged on the post-shift words
	logic norm_skip;
	always_comb begin
		norm_skip = 1'b0;
		unique case (jfield)
			scu_pkg::J_NEVER: norm_skip = 1'b0;
			scu_pkg::J_ALWAYS: norm_skip = 1'b1;
			scu_pkg::J_AUX_POS: norm_skip = !is_neg(res_aux);
			scu_pkg::J_AUX_NEG: norm_skip = is_neg(res_aux);
			// Both zeros count as zero in ones complement
			scu_pkg::J_ACC_ZERO: norm_skip = (res_acc == 30'h0) || (&res_acc);
			scu_pkg::J_ACC_NZ: norm_skip = !((res_acc == 30'h0) || (&res_acc));
			scu_pkg::J_ACC_POS: norm_skip = !is_neg(res_acc);
			scu_pkg::J_ACC_NEG: norm_skip = is_neg(res_acc);
		endcase
	end

	wire logic is_cmp = (op == scu_pkg::SCU_COMPARE);
	wire logic nxt_skip = is_cmp ? cmp_skip : norm_skip;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Compare leaves words alone; external load yields to start
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_ff <= 30'h0;
			aux_ff <= 30'h0;
		end else if (start && !is_cmp) begin
			acc_ff <= res_acc;
			aux_ff <= res_aux;
		end else if (!start) begin
			if (load_acc)
				acc_ff <= load_data;
			if (load_aux)
				aux_ff <= load_data;
		end
	end

	// One-cycle done with skip held until the next start
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			done_ff <= 1'b0;
			skip_ff <= 1'b0;
		end else begin
			done_ff <= start;
			if (start)
				skip_ff <= nxt_skip;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence shift_req(scu_pkg::scu_op_t o, scu_pkg::scu_sel_t s);
		start && op == o && sel == s;
	endsequence

	property p_done_follows;
		@(posedge clock) disable iff (rst) start |=> done_ff;
	endproperty

	done_follows_a: assert property (p_done_follows)
		else $error("done did not follow start");

	cmp_keeps_regs_a: assert property (@(posedge clock) disable iff (rst)
		start && is_cmp |=> $stable(acc_ff) && $stable(aux_ff))
		else $error("compare changed a register");

	aux_right_fill_a: assert property (@(posedge clock) disable iff (rst)
		shift_req(scu_pkg::SCU_SHIFT_RIGHT, scu_pkg::SCU_SEL_AUX)
		and (cnt >= scu_pkg::FULL_FILL_COUNT && cnt <= scu_pkg::MAX_COUNT)
		|=> aux_ff == {30{$past(aux_sign)}})
		else $error("aux right shift not full sign");

	acc_right_match_a: assert property (@(posedge clock) disable iff (rst)
		shift_req(scu_pkg::SCU_SHIFT_RIGHT, scu_pkg::SCU_SEL_ACC)
		and (cnt <= scu_pkg::MAX_COUNT)
		|=> acc_ff == 30'($signed({$past(acc_sign), $past(acc_ff)})
		>>> $past(cnt)))
		else $error("acc right shift wrong");

	pair_right_29_a: assert property (@(posedge clock) disable iff (rst)
		shift_req(scu_pkg::SCU_SHIFT_RIGHT, scu_pkg::SCU_SEL_PAIR)
		and cnt == scu_pkg::FULL_FILL_COUNT
		|=> acc_ff == {30{$past(acc_sign)}}
		&& aux_ff[29] == $past(acc_ff[28]))
		else $error("pair right 29 wrong");

	rotate_30_same_a: assert property (@(posedge clock) disable iff (rst)
		shift_req(scu_pkg::SCU_ROTATE_LEFT, scu_pkg::SCU_SEL_AUX)
		and cnt == 6'h1E |=> $stable(aux_ff))
		else $error("aux rotate 30 changed word");

	pair_swap_a: assert property (@(posedge clock) disable iff (rst)
		shift_req(scu_pkg::SCU_ROTATE_LEFT, scu_pkg::SCU_SEL_PAIR)
		and cnt == 6'h1E
		|=> acc_ff == $past(aux_ff) && aux_ff == $past(acc_ff))
		else $error("pair rotate 30 did not swap");

	zero_order_a: assert property (@(posedge clock) disable iff (rst)
		start && is_cmp && jfield == scu_pkg::J_GT_ACC
		&& operand == 30'h0 && acc_ff == 30'h3FFFFFFF
		|=> skip_ff)
		else $error("+0 not above -0");

	range_pair_only_a: assert property (@(posedge clock) disable iff (rst)
		start && is_cmp && sel != scu_pkg::SCU_SEL_PAIR
		&& (jfield == scu_pkg::J_IN_RANGE || jfield == scu_pkg::J_OUT_RANGE)
		|=> !skip_ff)
		else $error("range skip outside pair compare");

	norm_never_a: assert property (@(posedge clock) disable iff (rst)
		start && !is_cmp && jfield == scu_pkg::J_NEVER |=> !skip_ff)
		else $error("code 0 skipped");

endmodule

// ===== bench/scu_seq_model.sv
// Sequencer model that feeds the shift and compare datapath.
// Assumes every task is entered just after a falling clock edge.
`timescale 1ns/10ps

module scu_seq_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic done_ff,
	input wire logic skip_ff,
	output scu_pkg::scu_op_t op,
	output scu_pkg::scu_sel_t sel,
	output logic start,
	output logic [29:0] operand,
	output logic [2:0] jfield,
	output logic load_acc,
	output logic load_aux,
	output logic [29:0] load_data,
	output int pc_ff
);
	// ------------------------------------------------------------
	// Program address
	// ------------------------------------------------------------
	// A skip moves past the next instruction, not onto it
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			pc_ff <= 0;
		else if (done_ff)
			pc_ff <= pc_ff + (skip_ff ? 2 : 1);
	end

	// Quiet lines at time zero
	initial begin
		start = 1'b0;
		op = scu_pkg::SCU_SHIFT_RIGHT;
		sel = scu_pkg::SCU_SEL_AUX;
		operand = 30'h0;
		jfield = 3'h0;
		load_acc = 1'b0;
		load_aux = 1'b0;
		load_data = 30'h0;
	end

	// ------------------------------------------------------------
	// Requests
	// ------------------------------------------------------------
	// Back keeps start high so the next call lands next cycle
	task automatic issue(logic [1:0] o, s, logic [29:0] y,
		logic [2:0] j, logic ld, back);
		op = scu_pkg::scu_op_t'(o);
		sel = scu_pkg::scu_sel_t'(s);
		operand = y;
		jfield = j;
		start = 1'b1;
		// Load lines touched only when a refused load is wanted
		if (ld) begin
			load_acc = 1'b1;
			load_data = ~y;
		end
		@(negedge clock);
		if (!back) begin
			start = 1'b0;
			operand = ~y; // Released lines never show the old word
			jfield = ~j;
		end
		if (ld)
			load_acc = 1'b0;
	endtask

	// Two cycles, since both words share one data bus
	task automatic load(logic [29:0] a, q);
		load_acc = 1'b1;
		load_data = a;
		@(negedge clock);
		load_acc = 1'b0;
		load_aux = 1'b1;
		load_data = q;
		@(negedge clock);
		load_aux = 1'b0;
		load_data = ~q;
	endtask
endmodule

// ===== bench/tb_shift_compare_unit.sv
// Self-checking bench for the shift and compare datapath.
// Assumes the design answers one cycle after each start.
`timescale 1ns/10ps

module tb_shift_compare_unit;
	typedef struct {logic [1:0] o; logic [1:0] s; logic [29:0] y;
		logic [2:0] j; logic [29:0] a; logic [29:0] q;
		logic [60:0] e;} scu_row_t;
	localparam logic [29:0] N = 30'h25F1C3A5;
	localparam logic [29:0] P = 30'h0A5C3E1B;
	localparam logic [29:0] M = 30'h3FFFFFFF;
	logic clock, rst, start, load_acc, load_aux, done_ff, skip_ff;
	logic [29:0] operand, load_data, acc_ff, aux_ff;
	logic [2:0] jfield;
	scu_pkg::scu_op_t op;
	scu_pkg::scu_sel_t sel;
	int pc_ff, mismatches, n_checks, steps, cyc;
	scu_row_t rows[$];

	scu_shift_compare dut (.clock, .rst, .start, .op, .sel, .operand,
		.jfield, .load_acc, .load_aux, .load_data, .acc_ff, .aux_ff,
		.done_ff, .skip_ff);
	scu_seq_model seq (.clock, .rst, .done_ff, .skip_ff, .op, .sel,
		.start, .operand, .jfield, .load_acc, .load_aux, .load_data,
		.pc_ff);

	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	// Rank keeps +0 just above -0
	function automatic longint rk(logic [29:0] v);
		logic [29:0] m;
		m = ~v;
		return v[29] ? -2 * longint'(m) : 2 * longint'(v) + 1;
	endfunction

	// Op 0 right, 1 left, 2 compare; sel 0 aux, 1 acc, 2 pair
	function automatic logic [60:0] ref_f(scu_row_t r);
		logic [29:0] a, q;
		logic [59:0] p;
		int c;
		logic sk, z, pr, inr;
		a = r.a;
		q = r.q;
		c = r.y[5:0];
		pr = r.s == 2'h2;
		inr = pr && rk(q) >= rk(r.y) && rk(r.y) > rk(a);
		p = {a, q};
		if (r.o == 2'h0 && pr) p = $signed(p) >>> c;
		if (r.o == 2'h1 && pr) p = (p << c) | (p >> (60 - c));
		{a, q} = p;
		if (r.o == 2'h0 && r.s == 2'h1) a = $signed(a) >>> c;
		if (r.o == 2'h0 && r.s == 2'h0) q = $signed(q) >>> c;
		c = c % 30;
		if (r.o == 2'h1 && r.s == 2'h1) a = (a << c) | (a >> (30 - c));
		if (r.o == 2'h1 && r.s == 2'h0) q = (q << c) | (q >> (30 - c));
		z = a == 30'h0 || &a;
		case (r.j)
			3'h0: sk = 1'b0;
			3'h1: sk = 1'b1;
			3'h2: sk = r.o == 2'h2 ? rk(r.y) <= rk(q) : !q[29];
			3'h3: sk = r.o == 2'h2 ? rk(r.y) > rk(q) : q[29];
			3'h4: sk = r.o == 2'h2 ? inr : z;
			3'h5: sk = r.o == 2'h2 ? pr && !inr : !z;
			3'h6: sk = r.o == 2'h2 ? rk(r.y) <= rk(a) : !a[29];
			3'h7: sk = r.o == 2'h2 ? rk(r.y) > rk(a) : a[29];
		endcase
		return {a, q, sk};
	endfunction

	task automatic add(logic [1:0] o, s, logic [29:0] y, logic [2:0] j,
		logic [29:0] a, q);
		scu_row_t r;
		r = '{o, s, y, j, a, q, 61'h0};
		r.e = ref_f(r);
		rows.push_back(r);
	endtask

	task automatic chk(logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Whole run is under a hundred cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		repeat (4) @(negedge clock);
		rst = 1'b0;
		chk({acc_ff, aux_ff, done_ff, skip_ff}, 62'h0);
		// Upper operand bits must not reach the count
		add(2'h0, 2'h0, 30'h8, 3'h3, P, N);
		add(2'h0, 2'h0, 30'h1D, 3'h2, P, P);
		add(2'h0, 2'h0, 30'h3B, 3'h0, P, N);
		add(2'h0, 2'h0, 30'h2AAAAA5C, 3'h1, P, N);
		add(2'h0, 2'h1, 30'h1D, 3'h7, N, P);
		add(2'h0, 2'h1, 30'h5, 3'h6, P, N);
		add(2'h0, 2'h2, 30'hC, 3'h4, P, N);
		add(2'h0, 2'h2, 30'h1D, 3'h5, N, P);
		add(2'h0, 2'h2, 30'h3B, 3'h7, N, P);
		add(2'h0, 2'h2, 30'h0, 3'h4, 30'h0, N);
		add(2'h1, 2'h0, 30'h1E, 3'h0, P, N);
		add(2'h1, 2'h0, 30'hF, 3'h2, P, N);
		add(2'h1, 2'h1, 30'h2D, 3'h5, N, P);
		add(2'h1, 2'h1, 30'h1, 3'h6, N, P);
		add(2'h1, 2'h2, 30'h1E, 3'h3, P, N);
		add(2'h1, 2'h2, 30'h6, 3'h7, N, P);
		add(2'h1, 2'h2, 30'h3B, 3'h4, M, M);
		add(2'h2, 2'h0, P, 3'h2, N, P);
		add(2'h2, 2'h0, M, 3'h3, N, 30'h0);
		add(2'h2, 2'h1, 30'h0, 3'h7, M, P);
		add(2'h2, 2'h1, N, 3'h6, P, N);
		add(2'h2, 2'h2, 30'h0, 3'h4, N, P);
		add(2'h2, 2'h2, 30'h0, 3'h5, N, P);
		add(2'h2, 2'h1, 30'h0, 3'h4, N, P);
		add(2'h2, 2'h2, 30'h0, 3'h0, N, P);
		add(2'h2, 2'h2, 30'h0, 3'h1, N, P);
		foreach (rows[i]) begin
			seq.load(rows[i].a, rows[i].q);
			seq.issue(rows[i].o, rows[i].s, rows[i].y, rows[i].j, 0, 0);
			chk({acc_ff, aux_ff, skip_ff, done_ff}, {rows[i].e, 1'b1});
			steps += rows[i].e[0] ? 2 : 1;
		end
		@(negedge clock);
		chk(64'(pc_ff), 64'(steps));
		// Back-to-back starts, then a load during a start
		seq.load(30'h1, 30'h20000001);
		seq.issue(2'h1, 2'h0, 30'h1, 3'h0, 0, 1);
		chk(aux_ff, 30'h3);
		seq.issue(2'h1, 2'h0, 30'h1, 3'h0, 0, 1);
		chk({aux_ff, done_ff}, {30'h6, 1'b1});
		seq.issue(2'h2, 2'h2, 30'h5, 3'h1, 1, 0);
		chk({acc_ff, aux_ff, skip_ff}, {30'h1, 30'h6, 1'b1});
		// Second reset in mid-run clears everything
		rst = 1'b1;
		@(negedge clock);
		rst = 1'b0;
		chk({acc_ff, aux_ff, done_ff, skip_ff}, 62'h0);
		give_verdict();
	end
endmodule
